// File: include/ccpt_pkg.sv
// Package of constants and types for the capture/compare/PWM timer.
package ccpt_pkg;
	// ==========================================================
	// Geometry
	localparam int unsigned CCPT_CHANNELS = 4;
	localparam int unsigned CCPT_NARROW_WIDTH = 16;
	localparam int unsigned CCPT_WIDE_WIDTH = 32;
	localparam int unsigned CCPT_DEAD_WIDTH = 8;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] CCPT_CTRL_OFF = 8'h00;
	localparam logic [7:0] CCPT_CMD_OFF = 8'h04;
	localparam logic [7:0] CCPT_STATUS_OFF = 8'h08;
	localparam logic [7:0] CCPT_IRQ_STAT_OFF = 8'h0C;
	localparam logic [7:0] CCPT_IRQ_MASK_OFF = 8'h10;
	localparam logic [7:0] CCPT_COUNT_OFF = 8'h14;
	localparam logic [7:0] CCPT_TOP_OFF = 8'h18;
	localparam logic [7:0] CCPT_DEAD_OFF = 8'h1C;
	localparam logic [7:0] CCPT_CH_CTRL_OFF = 8'h20;
	localparam logic [7:0] CCPT_CH_VAL_OFF = 8'h30;
	localparam logic [7:0] CCPT_CH_CAP_OFF = 8'h40;

	// ==========================================================
	// Field positions
	localparam int unsigned CCPT_CTRL_RUN_BIT = 0;
	localparam int unsigned CCPT_CTRL_EVT_BIT = 1;
	localparam int unsigned CCPT_CTRL_DT_EN_BIT = 2;
	localparam int unsigned CCPT_CMD_CLEAR_BIT = 0;
	localparam int unsigned CCPT_IRQ_OVF_BIT = 0;
	localparam int unsigned CCPT_IRQ_CH_LSB = 1;
	localparam int unsigned CCPT_IRQ_WIDTH = 5;
	localparam int unsigned CCPT_CHCTL_MODE_LSB = 0;
	localparam int unsigned CCPT_CHCTL_EDGE_LSB = 2;

	// ==========================================================
	// Reset values
	localparam logic [31:0] CCPT_TOP_RESET = 32'hFFFF_FFFF;
	localparam logic [31:0] CCPT_ZERO = 32'h0000_0000;

	// ==========================================================
	// Channel modes and capture edges
	typedef enum logic [1:0] {
		CCPT_MODE_OFF = 2'h0,
		CCPT_MODE_CAPTURE = 2'h1,
		CCPT_MODE_COMPARE = 2'h3,
		CCPT_MODE_PWM = 2'h2
	} ccpt_mode_t;

	typedef enum logic [1:0] {
		CCPT_EDGE_RISE = 2'h0,
		CCPT_EDGE_FALL = 2'h1,
		CCPT_EDGE_BOTH = 2'h3,
		CCPT_EDGE_NONE = 2'h2
	} ccpt_edge_t;

	// AXI4-Lite response codes.
	localparam logic [1:0] CCPT_RESP_OKAY = 2'h0;
	localparam logic [1:0] CCPT_RESP_SLVERR = 2'h2;
endpackage

// File: logic/ccpt_deadtime.sv
// Dead-time inserter producing a complementary output pair.
`timescale 1ns/10ps
module ccpt_deadtime (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic [ccpt_pkg::CCPT_DEAD_WIDTH-1:0] dead_cycles,
	input wire logic pwm_in,
	output logic out_high,
	output logic out_low
);
	import ccpt_pkg::*;

	logic prev_reg, prev_next;
	logic [CCPT_DEAD_WIDTH-1:0] wait_reg, wait_next;
	logic hi_reg, hi_next, lo_reg, lo_next;

	// ==========================================================
	// Dead time
	// Both legs go low on any edge and the new leg rises only after the gap, so the pair never overlaps.
	always_comb begin
		prev_next = pwm_in;
		wait_next = wait_reg;
		hi_next = hi_reg;
		lo_next = lo_reg;
		if (!enable) begin
			hi_next = pwm_in;
			lo_next = !pwm_in;
			wait_next = '0;
		end else if (pwm_in != prev_reg) begin
			hi_next = 1'b0;
			lo_next = 1'b0;
			wait_next = dead_cycles;
		end else if (wait_reg != '0) begin
			wait_next = wait_reg - 1'b1;
		end else begin
			hi_next = pwm_in;
			lo_next = !pwm_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_reg <= 1'b0;
			wait_reg <= '0;
			hi_reg <= 1'b0;
			lo_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
			wait_reg <= wait_next;
			hi_reg <= hi_next;
			lo_reg <= lo_next;
		end
	end

	assign out_high = hi_reg;
	assign out_low = lo_reg;
endmodule // ccpt_deadtime

// File: logic/ccpt_timer.sv
// Capture/compare/PWM timer with an AXI4-Lite register port.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Notes on behaviour
// - The narrow build uses a 16-bit counter with four channels that each compare or capture.
// - The wide build behaves the same but its counter and all counter-valued registers are 32 bits.
// - Each channel mode other than off selects exactly one of capture, compare or PWM.
// - In capture mode the selected input event copies the counter into the channel capture register.
// - In compare mode the channel output follows the counter-versus-threshold comparison.
// - In PWM mode the output follows the compare value software writes, taken only when the counter wraps at TOP.
// - Dead-time insertion on complementary outputs exists only in a unit built with FIRST_UNIT set, whatever its width.
// - The counter advances either on clock time or on counted external events.
// - The timer drives trigger pulses onto the reflex event network.
module ccpt_timer #(
	parameter int unsigned WIDTH = ccpt_pkg::CCPT_NARROW_WIDTH,
	parameter bit FIRST_UNIT = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic count_event,
	input wire logic [ccpt_pkg::CCPT_CHANNELS-1:0] capture_in,
	output logic [ccpt_pkg::CCPT_CHANNELS-1:0] channel_out,
	output logic [ccpt_pkg::CCPT_CHANNELS-1:0] channel_out_n,
	output logic [ccpt_pkg::CCPT_IRQ_WIDTH-1:0] reflex_event_network,
	output logic irq
);
	import ccpt_pkg::*;

	localparam int unsigned NCH = CCPT_CHANNELS;

	// ==========================================================
	// State
	logic [2:0] ctrl_reg, ctrl_next;
	logic [CCPT_IRQ_WIDTH-1:0] stat_reg, stat_next, mask_reg, mask_next;
	logic [WIDTH-1:0] count_reg, count_next, top_reg, top_next;
	logic [CCPT_DEAD_WIDTH-1:0] dead_reg, dead_next;
	logic [3:0] chctl_reg [NCH], chctl_next [NCH];
	logic [WIDTH-1:0] val_reg [NCH], val_next [NCH];
	logic [WIDTH-1:0] act_reg [NCH], act_next [NCH];
	logic [WIDTH-1:0] cap_reg [NCH], cap_next [NCH];
	logic [NCH-1:0] cin_prev_reg, cin_prev_next, out_reg, out_next;
	logic evt_prev_reg, evt_prev_next;
	logic [CCPT_IRQ_WIDTH-1:0] trig_reg, trig_next;
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next, bvalid_reg, bvalid_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;

	logic do_write, do_read, tick, wrap;
	logic [CCPT_IRQ_WIDTH-1:0] events;
	logic [31:0] wmask;

	// ==========================================================
	// AXI4-Lite handshake
	// Address and data are latched independently, so either may arrive first.
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready = !w_hold_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign do_read = s_axi_arvalid && !rvalid_reg;
	assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	// Counter advance and wrap.
	assign tick = ctrl_reg[CCPT_CTRL_RUN_BIT] &&
		(ctrl_reg[CCPT_CTRL_EVT_BIT] ? (count_event && !evt_prev_reg) : 1'b1);
	assign wrap = tick && (count_reg == top_reg);

	// ==========================================================
	// Channel event detection
	always_comb begin
		events = '0;
		events[CCPT_IRQ_OVF_BIT] = wrap;
		for (int i = 0; i < NCH; i++) begin
			case (ccpt_mode_t'(chctl_reg[i][1:0]))
				CCPT_MODE_CAPTURE: begin
					case (ccpt_edge_t'(chctl_reg[i][3:2]))
						CCPT_EDGE_RISE: events[CCPT_IRQ_CH_LSB+i] = capture_in[i] && !cin_prev_reg[i];
						CCPT_EDGE_FALL: events[CCPT_IRQ_CH_LSB+i] = !capture_in[i] && cin_prev_reg[i];
						CCPT_EDGE_BOTH: events[CCPT_IRQ_CH_LSB+i] = capture_in[i] != cin_prev_reg[i];
						default: events[CCPT_IRQ_CH_LSB+i] = 1'b0;
					endcase
				end
				CCPT_MODE_COMPARE, CCPT_MODE_PWM: events[CCPT_IRQ_CH_LSB+i] = tick && (count_reg == act_reg[i]);
				default: events[CCPT_IRQ_CH_LSB+i] = 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Register file, counter and channels
	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		top_next = top_reg;
		dead_next = dead_reg;
		count_next = count_reg;
		chctl_next = chctl_reg;
		val_next = val_reg;
		act_next = act_reg;
		cap_next = cap_reg;
		out_next = out_reg;
		stat_next = stat_reg;
		if (tick) begin
			count_next = wrap ? '0 : WIDTH'(count_reg + 1'b1);
		end
		for (int i = 0; i < NCH; i++) begin
			case (ccpt_mode_t'(chctl_reg[i][1:0]))
				CCPT_MODE_CAPTURE: begin
					if (events[CCPT_IRQ_CH_LSB+i]) begin
						cap_next[i] = count_reg;
					end
					out_next[i] = 1'b0;
				end
				CCPT_MODE_COMPARE: begin
					act_next[i] = val_reg[i];
					out_next[i] = count_reg >= act_reg[i];
				end
				CCPT_MODE_PWM: begin
					// New duty is taken only at wrap so a period is never cut short.
					if (wrap) begin
						act_next[i] = val_reg[i];
					end
					out_next[i] = count_reg < act_reg[i];
				end
				default: out_next[i] = 1'b0;
			endcase
		end
		if (do_write) begin
			case (awaddr_reg)
				CCPT_CTRL_OFF: ctrl_next = wdata_reg[2:0];
				CCPT_CMD_OFF: if (wdata_reg[CCPT_CMD_CLEAR_BIT]) count_next = '0;
				CCPT_IRQ_STAT_OFF: stat_next = stat_reg & ~wdata_reg[CCPT_IRQ_WIDTH-1:0];
				CCPT_IRQ_MASK_OFF: mask_next = wdata_reg[CCPT_IRQ_WIDTH-1:0];
				CCPT_COUNT_OFF: count_next = wdata_reg[WIDTH-1:0];
				CCPT_TOP_OFF: top_next = wdata_reg[WIDTH-1:0];
				CCPT_DEAD_OFF: dead_next = wdata_reg[CCPT_DEAD_WIDTH-1:0];
				default: begin
					for (int i = 0; i < NCH; i++) begin
						if (awaddr_reg == CCPT_CH_CTRL_OFF + 8'(4 * i)) chctl_next[i] = wdata_reg[3:0];
						if (awaddr_reg == CCPT_CH_VAL_OFF + 8'(4 * i)) val_next[i] = wdata_reg[WIDTH-1:0];
					end
				end
			endcase
		end
		// Setting wins over a simultaneous write-one-to-clear.
		stat_next = stat_next | events;
	end

	// ==========================================================
	// Bus state next values
	always_comb begin
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_next = 1'b1;
			awaddr_next = {s_axi_awaddr[7:2], 2'h0};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_next = 1'b1;
			wdata_next = s_axi_wdata & wmask;
		end
		if (do_write) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (awaddr_reg <= CCPT_CH_VAL_OFF + 8'h0C && awaddr_reg != CCPT_STATUS_OFF) ?
				CCPT_RESP_OKAY : CCPT_RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (do_read) begin
			rvalid_next = 1'b1;
			rresp_next = CCPT_RESP_OKAY;
			rdata_next = CCPT_ZERO;
			case ({s_axi_araddr[7:2], 2'h0})
				CCPT_CTRL_OFF: rdata_next = 32'(ctrl_reg);
				CCPT_CMD_OFF: rdata_next = CCPT_ZERO;
				CCPT_STATUS_OFF: rdata_next = 32'({out_reg, ctrl_reg[CCPT_CTRL_RUN_BIT]});
				CCPT_IRQ_STAT_OFF: rdata_next = 32'(stat_reg);
				CCPT_IRQ_MASK_OFF: rdata_next = 32'(mask_reg);
				CCPT_COUNT_OFF: rdata_next = 32'(count_reg);
				CCPT_TOP_OFF: rdata_next = 32'(top_reg);
				CCPT_DEAD_OFF: rdata_next = 32'(dead_reg);
				default: begin
					rresp_next = CCPT_RESP_SLVERR;
					for (int i = 0; i < NCH; i++) begin
						if ({s_axi_araddr[7:2], 2'h0} == CCPT_CH_CTRL_OFF + 8'(4 * i)) begin
							rdata_next = 32'(chctl_reg[i]);
							rresp_next = CCPT_RESP_OKAY;
						end
						if ({s_axi_araddr[7:2], 2'h0} == CCPT_CH_VAL_OFF + 8'(4 * i)) begin
							rdata_next = 32'(val_reg[i]);
							rresp_next = CCPT_RESP_OKAY;
						end
						if ({s_axi_araddr[7:2], 2'h0} == CCPT_CH_CAP_OFF + 8'(4 * i)) begin
							rdata_next = 32'(cap_reg[i]);
							rresp_next = CCPT_RESP_OKAY;
						end
					end
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	assign cin_prev_next = capture_in;
	assign evt_prev_next = count_event;
	assign trig_next = events;

	// ==========================================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= '0;
			stat_reg <= '0;
			mask_reg <= '0;
			count_reg <= '0;
			top_reg <= CCPT_TOP_RESET[WIDTH-1:0];
			dead_reg <= '0;
			for (int i = 0; i < NCH; i++) begin
				chctl_reg[i] <= '0;
				val_reg[i] <= '0;
				act_reg[i] <= '0;
				cap_reg[i] <= '0;
			end
			cin_prev_reg <= '0;
			out_reg <= '0;
			evt_prev_reg <= 1'b0;
			trig_reg <= '0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= CCPT_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= CCPT_RESP_OKAY;
		end else begin
			ctrl_reg <= ctrl_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			count_reg <= count_next;
			top_reg <= top_next;
			dead_reg <= dead_next;
			chctl_reg <= chctl_next;
			val_reg <= val_next;
			act_reg <= act_next;
			cap_reg <= cap_next;
			cin_prev_reg <= cin_prev_next;
			out_reg <= out_next;
			evt_prev_reg <= evt_prev_next;
			trig_reg <= trig_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// ==========================================================
	// Outputs
	// Other units only see registered one-cycle trigger pulses.
	assign reflex_event_network = trig_reg;
	assign irq = |(stat_reg & mask_reg);
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Complementary pairs; only the first unit gets real dead-time logic.
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_pair
			if (FIRST_UNIT) begin : g_dt
				ccpt_deadtime u_dt (
					.aclk(aclk),
					.aresetn(aresetn),
					.enable(ctrl_reg[CCPT_CTRL_DT_EN_BIT]),
					.dead_cycles(dead_reg),
					.pwm_in(out_reg[g]),
					.out_high(channel_out[g]),
					.out_low(channel_out_n[g])
				);
			end else begin : g_plain
				assign channel_out[g] = out_reg[g];
				assign channel_out_n[g] = !out_reg[g];
			end
		end
	endgenerate
endmodule // ccpt_timer

// File: tb/ccpt_chk.sv
// Port-level assertions for the capture/compare/PWM timer.
`timescale 1ns/10ps
module ccpt_chk #(
	parameter bit FIRST_UNIT = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ccpt_pkg::CCPT_CHANNELS-1:0] channel_out,
	input wire logic [ccpt_pkg::CCPT_CHANNELS-1:0] channel_out_n,
	input wire logic [ccpt_pkg::CCPT_IRQ_WIDTH-1:0] reflex_event_network,
	input wire logic irq
);
	import ccpt_pkg::*;
	// ========
	// Checks. All share the one clock and its reset.
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && !(|reflex_event_network))
		else $error("output active just after reset");
	chk_compl_pair: assert property (FIRST_UNIT || (channel_out_n == ~channel_out))
		else $error("plain unit outputs not complementary");
	chk_ovf_pulse: assert property (reflex_event_network[0] |=> !reflex_event_network[0])
		else $error("overflow trigger longer than one cycle");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read data missing");
	chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data withdrawn early");
endmodule // ccpt_chk

bind ccpt_timer ccpt_chk #(.FIRST_UNIT(FIRST_UNIT)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .channel_out, .channel_out_n, .reflex_event_network, .irq);

// File: tb/ccpt_partner.sv
// Far-side model: event and capture source, and consumer of routed triggers.
`timescale 1ns/10ps
module ccpt_partner (
	input wire logic aclk,
	input wire logic [ccpt_pkg::CCPT_IRQ_WIDTH-1:0] reflex_event_network,
	output logic count_event,
	output logic [ccpt_pkg::CCPT_CHANNELS-1:0] capture_in
);
	import ccpt_pkg::*;
	int trig_seen [CCPT_IRQ_WIDTH];
	// Lines idle low until a pulse is asked for.
	initial begin
		count_event = 1'b0;
		capture_in = 4'h0;
	end
	// Triggers are single-cycle, so each high sample is one event.
	always @(posedge aclk) begin
		for (int i = 0; i < CCPT_IRQ_WIDTH; i++) begin
			if (reflex_event_network[i] === 1'b1) begin
				trig_seen[i]++;
			end
		end
	end
	// Two cycles high and two low, so each level is seen by the edge detector.
	task automatic pulse_count(input int n);
		repeat (n) begin
			count_event <= 1'b1;
			repeat (2) @(posedge aclk);
			count_event <= 1'b0;
			repeat (2) @(posedge aclk);
		end
	endtask
	// One rising and one falling edge on a capture line.
	task automatic pulse_capture(input int ch);
		capture_in[ch] <= 1'b1;
		repeat (2) @(posedge aclk);
		capture_in[ch] <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
endmodule // ccpt_partner

// File: tb/ccpt_timer_test.sv
// Self-checking bench for a narrow plain timer and a wide first unit sharing one register bus.
`timescale 1ns/10ps
module ccpt_timer_test;
	import ccpt_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, count_event;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [31:0] s_axi_rdata, rd;
	logic [CCPT_CHANNELS-1:0] capture_in, channel_out, channel_out_n;
	logic [CCPT_IRQ_WIDTH-1:0] reflex_event_network;
	int err_total = 0, checks_done = 0, cycles = 0, hi;
	int whi, ovl;
	logic [31:0] w_rdata, wd;
	logic [CCPT_CHANNELS-1:0] w_out, w_out_n;

	ccpt_timer #(.WIDTH(CCPT_NARROW_WIDTH), .FIRST_UNIT(1'b0)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .count_event, .capture_in, .channel_out, .channel_out_n, .reflex_event_network, .irq);
	// The wide first unit answers in lockstep with u_dut, so only its read data and channel pair are watched.
	ccpt_timer #(.WIDTH(CCPT_WIDE_WIDTH), .FIRST_UNIT(1'b1)) u_wide (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(w_rdata), .s_axi_rresp(),
		.s_axi_rvalid(), .s_axi_rready, .count_event, .capture_in, .channel_out(w_out), .channel_out_n(w_out_n),
		.reflex_event_network(), .irq());
	ccpt_partner u_far (.aclk, .reflex_event_network, .count_event, .capture_in);

	// ========
	// Clock, and a cycle ceiling so a hung handshake cannot stall the run.
	always #50 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			$display("[ERR] %0t timeout", $time);
			tally_and_finish();
		end
	end

	// ========
	// Helpers. Every request is driven just after an edge and held until taken.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = CCPT_RESP_OKAY);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
		@(posedge aclk);
	endtask
	// Ready for the answer goes up with the address and stays up until the data are taken.
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		wd = w_rdata;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		axi_rd(a, rd, rr);
		chk(rd, exp, what);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ========
	// Test sequence.
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(CCPT_TOP_OFF, 32'h0000_FFFF, "top after reset");
		chk(wd, 32'hFFFF_FFFF, "wide top after reset");
		rd_chk(CCPT_IRQ_STAT_OFF, CCPT_ZERO, "flags after reset");
		axi_rd(8'hFC, rd, rr);
		chk({30'h0, rr}, {30'h0, CCPT_RESP_SLVERR}, "unmapped read");
		axi_wr(CCPT_STATUS_OFF, 32'h0000_001F, CCPT_RESP_SLVERR);
		rd_chk(CCPT_STATUS_OFF, CCPT_ZERO, "status is read only");
		axi_wr(CCPT_COUNT_OFF, 32'h0001_2345);
		rd_chk(CCPT_COUNT_OFF, 32'h0000_2345, "count keeps 16 bits");
		chk(wd, 32'h0001_2345, "wide count keeps 32 bits");
		$display("test map done");
		// Time base wraps at TOP, with the flag first masked, then routed to irq and cleared.
		axi_wr(CCPT_TOP_OFF, 32'h0000_0009);
		axi_wr(CCPT_CMD_OFF, 32'h0000_0001);
		hi = u_far.trig_seen[0];
		axi_wr(CCPT_CTRL_OFF, 32'h0000_0001);
		repeat (30) @(posedge aclk);
		axi_wr(CCPT_CTRL_OFF, CCPT_ZERO);
		hi = u_far.trig_seen[0] - hi;
		chk(32'(hi >= 2 && hi <= 4), 32'h1, "overflow triggers");
		axi_rd(CCPT_COUNT_OFF, rd, rr);
		chk(32'(rd <= 32'h9), 32'h1, "count stays within top");
		chk({31'h0, irq}, CCPT_ZERO, "masked irq");
		rd_chk(CCPT_IRQ_STAT_OFF, 32'h0000_0001, "overflow flag");
		axi_wr(CCPT_IRQ_MASK_OFF, 32'h0000_0001);
		chk({31'h0, irq}, 32'h1, "unmasked irq");
		axi_wr(CCPT_IRQ_STAT_OFF, 32'h0000_0001);
		rd_chk(CCPT_IRQ_STAT_OFF, CCPT_ZERO, "flag cleared");
		chk({31'h0, irq}, CCPT_ZERO, "irq after clear");
		$display("test overflow done");
		// Event mode counts rising edges only.
		axi_wr(CCPT_CMD_OFF, 32'h0000_0001);
		axi_wr(CCPT_CTRL_OFF, 32'h0000_0003);
		u_far.pulse_count(5);
		axi_wr(CCPT_CTRL_OFF, CCPT_ZERO);
		rd_chk(CCPT_COUNT_OFF, 32'h0000_0005, "events counted");
		$display("test events done");
		// Every capture edge code on channel 0; the none code keeps the old value.
		hi = u_far.trig_seen[1];
		for (int e = 0; e < 4; e++) begin
			axi_wr(CCPT_CH_CTRL_OFF, {28'h0, e[1:0], 2'h1});
			axi_wr(CCPT_COUNT_OFF, 32'h0000_0100 + e);
			u_far.pulse_capture(0);
			rd_chk(CCPT_CH_CAP_OFF, (e == 2) ? 32'h0000_0101 : 32'h0000_0100 + e, "captured count");
		end
		chk(u_far.trig_seen[1] - hi, 32'h4, "capture triggers");
		rd_chk(CCPT_IRQ_STAT_OFF, 32'h0000_0002, "capture flag");
		$display("test capture done");
		// Compare output on channel 2 around its threshold.
		axi_wr(CCPT_CH_CTRL_OFF + 8'h08, 32'h0000_0003);
		axi_wr(CCPT_CH_VAL_OFF + 8'h08, 32'h0000_0005);
		for (int c = 4; c < 7; c++) begin
			axi_wr(CCPT_COUNT_OFF, 32'(c));
			repeat (2) @(posedge aclk);
			chk({31'h0, channel_out[2]}, 32'(c >= 5), "compare output");
		end
		$display("test compare done");
		// PWM on channel 3: duty follows each new value, dead-time asked for on a plain unit.
		axi_wr(CCPT_CH_CTRL_OFF + 8'h0C, 32'h0000_0002);
		axi_wr(CCPT_TOP_OFF, 32'h0000_0007);
		axi_wr(CCPT_DEAD_OFF, 32'h0000_0001);
		axi_wr(CCPT_CMD_OFF, 32'h0000_0001);
		axi_wr(CCPT_CTRL_OFF, 32'h0000_0005);
		for (int v = 3; v < 9; v += 3) begin
			axi_wr(CCPT_CH_VAL_OFF + 8'h0C, 32'(v));
			repeat (20) @(posedge aclk);
			hi = 0;
			whi = 0;
			ovl = 0;
			repeat (16) begin
				@(posedge aclk);
				hi += 32'(channel_out[3] === 1'b1);
				whi += 32'(w_out[3] === 1'b1);
				ovl += 32'(w_out[3] === 1'b1 && w_out_n[3] === 1'b1);
			end
			chk(32'(hi), 32'(2 * v), "pwm high cycles");
			// The first unit's high leg loses one cycle of edge detection plus the one-cycle gap per period.
			chk(32'(whi), 32'(2 * (v - 2)), "dead-time high cycles");
			chk(32'(ovl), CCPT_ZERO, "dead-time overlap");
		end
		axi_wr(CCPT_CTRL_OFF, CCPT_ZERO);
		$display("test pwm done");
		tally_and_finish();
	end
endmodule // ccpt_timer_test
